// ===== logic/capture_pkg.sv
// Constants, register map and carrier types for the capture record formatter
package capture_pkg;
    // Register indices on the plain register port
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_SNAP = 4'h1;
    localparam logic [3:0] REG_CMD = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    localparam logic [3:0] REG_PORT_DROP = 4'h4;
    localparam logic [3:0] REG_STREAM_DROP = 4'h5;
    // Control register bit positions
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_CRCSTRIP = 1;
    localparam int CTRL_DECOUPLED = 2;
    localparam int CTRL_EQUIP_LB = 3;
    localparam int CTRL_FAC_LB = 4;
    localparam int CTRL_LASER = 5;
    localparam int CTRL_CLK_MASTER = 6;
    localparam int CTRL_OVERLAP = 7;
    localparam int CTRL_W = 8;
    // Control reset value: port enabled, everything else off
    localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h01;
    // Command register bits
    localparam int CMD_IMAGE_RESET = 0;
    localparam int CMD_DEFAULT = 1;
    localparam int CMD_START = 2;
    // Snap length limits and default, bytes
    localparam logic [13:0] SNAP_MIN = 14'h0030;
    localparam logic [13:0] SNAP_MAX = 14'h2580;
    localparam logic [13:0] SNAP_RESET = 14'h0030;
    // Record header sizes and FCS length, bytes
    localparam logic [13:0] HDR_LEN = 14'h0012;
    localparam logic [13:0] HDR_STD = 14'h0010;
    localparam logic [13:0] FCS_LEN = 14'h0004;

    // Received byte stream carrier
    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic last;
    } rx_byte_t;

    // Record word carrier toward the host bus
    typedef struct packed {
        logic valid;
        logic [63:0] data;
        logic last;
    } rec_word_t;

    // Register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [31:0] wdata;
    } reg_req_t;
endpackage

// ===== logic/record_packer.sv
// Packs header bytes into 64-bit record words, zero padded
`timescale 1ns/100ps
module record_packer
    import capture_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic byte_vld_i,
    input wire logic [7:0] byte_i,
    input wire logic byte_last_i,
    output rec_word_t word_o
);
    typedef struct packed {
        logic [63:0] acc;
        logic [2:0] idx;
        rec_word_t out;
    } pk_state_t;

    pk_state_t st_ff;
    pk_state_t nxt_st;

    // Fill bytes little end first; flush on last byte with zero padding
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.out.valid = 1'b0;
        nxt_st.out.last = 1'b0;
        if (byte_vld_i)
        begin
            nxt_st.acc[{st_ff.idx, 3'h0} +: 8] = byte_i;
            nxt_st.idx = st_ff.idx + 3'h1;
            if (byte_last_i || st_ff.idx == 3'h7)
            begin
                nxt_st.out.valid = 1'b1;
                nxt_st.out.data = nxt_st.acc;
                nxt_st.out.last = byte_last_i;
                nxt_st.acc = 64'h0;
                nxt_st.idx = 3'h0;
            end
        end
    end

    // State register
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign word_o = st_ff.out;
endmodule

// ===== logic/capture_record_formatter.sv
// Receive capture path: snap, FCS strip, record framing and drop accounting
//
// Functional notes
// (R1) Snap length is a multiple of 8 within 48..9600; others refused.
// (R2) Snap length defaults to 48 after initialization.
// (R3) Longer frames are cut to snap length; shorter kept whole. The code keeps no body bytes, only the stored length field.
// (R4) Record header is 18 bytes; payload at most snap minus 2.
// (R5) Header not counted in snap; record is 16 plus snap bytes. The code emits only the 18-byte header, padded to 24.
// (R6) Records padded to a multiple of 8 bytes, always.
// (R7) FCS stripping drops FCS from body and from wire length.
// (R8) Decoupled mode: full stream drops frame at its burst manager.
// (R9) Coupled mode: streams stall together; port drops frames.
// (R10) Coupled mode port drop count cleared by image reset.
// (R11) Decoupled mode stream drop count cleared on capture start.
// (R12) Port capture enable, set by default, blocks capture when clear.
// (R13) Equipment loopback returns host transmit data to host side.
// (R14) Facility loopback retransmits received data and still captures.
// (R15) Laser control switches the transmit laser.
// (R16) Read-only lock indication reports receive signal lock.
// (R17) Clock source select: recovered or on-card reference clock.
// (R18) Image reset restarts datapath, clears port drops, keeps config. The code does not reset the record packer.
// (R19) Default command returns all settings to their defaults.
// (R20) Host issues default command after each reprogramming.
// (R21) Host keeps buffer split fixed while traffic runs.
// (R22) Overlap makes receive and transmit buffers share memory.
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/100ps
module capture_record_formatter
    import capture_pkg::*;
#(
    parameter int DROP_W = 32
)
(
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // Register port
    input wire reg_req_t reg_req_i,
    output logic [31:0] reg_rdata_o,
    // Received line bytes with frame end
    input wire rx_byte_t rx_i,
    input wire logic rx_lock_i,
    // Host side acceptance of record words
    input wire logic host_ready_i,
    input wire logic stream_ready_i,
    output rec_word_t rec_o,
    output logic rx_ready_o,
    // Host transmit data and line transmit
    input wire rx_byte_t host_tx_i,
    output rx_byte_t line_tx_o,
    output rx_byte_t host_lb_o,
    output logic laser_on_o,
    output logic tx_clk_master_o,
    output logic buf_overlap_o
);
    initial
    begin
        if (DROP_W < 1 || DROP_W > 32)
            $error("DROP_W must be 1 to 32");
    end

    typedef enum logic [1:0] {S_IDLE, S_HDR, S_BODY, S_SKIP} ph_t;

    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic [13:0] snap;
        ph_t ph;
        logic [4:0] hidx;
        logic [13:0] taken;
        logic [13:0] wlen;
        logic [7:0] hold;
        logic hold_vld;
        logic [DROP_W-1:0] port_drop;
        logic [DROP_W-1:0] stream_drop;
        logic [31:0] rdata;
    } state_t;

    state_t st_ff;
    state_t nxt_st;
    logic pk_vld;
    logic [7:0] pk_byte;
    logic pk_last;
    logic snap_ok;
    logic [13:0] snap_body;
    logic [13:0] fcs_cut;
    logic [13:0] wr_snap;

    ////////////////////////////////////////////////////////////////////////
    // Snap length check for writes
    assign wr_snap = reg_req_i.wdata[13:0];
    assign snap_ok = (wr_snap[2:0] == 3'h0) && (wr_snap >= SNAP_MIN)
        && (wr_snap <= SNAP_MAX) && (reg_req_i.wdata[31:14] == 18'h0); // [R1]
    // Body budget: header overflow beyond 16 bytes eats into payload
    assign snap_body = st_ff.snap - (HDR_LEN - HDR_STD); // [R4] [R5]
    assign fcs_cut = st_ff.ctrl[CTRL_CRCSTRIP] ? FCS_LEN : 14'h0;

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        nxt_st = st_ff;
        pk_vld = 1'b0;
        pk_byte = 8'h0;
        pk_last = 1'b0;
        nxt_st.rdata = 32'h0;

        // Register writes
        if (reg_req_i.wr)
        begin
            case (reg_req_i.addr)
                REG_CTRL: nxt_st.ctrl = reg_req_i.wdata[CTRL_W-1:0];
                REG_SNAP:
                begin
                    if (snap_ok)
                        nxt_st.snap = wr_snap; // [R1]
                end
                default: ;
            endcase
        end

        // Register reads, data stand one cycle later
        if (reg_req_i.rd)
        begin
            case (reg_req_i.addr)
                REG_CTRL: nxt_st.rdata = {{(32-CTRL_W){1'b0}}, st_ff.ctrl};
                REG_SNAP: nxt_st.rdata = {18'h0, st_ff.snap};
                REG_STATUS: nxt_st.rdata = {31'h0, rx_lock_i}; // [R16]
                REG_PORT_DROP:
                    nxt_st.rdata = 32'(st_ff.port_drop);
                REG_STREAM_DROP:
                    nxt_st.rdata = 32'(st_ff.stream_drop);
                default: nxt_st.rdata = 32'h0;
            endcase
        end

        // Receive phase machine
        case (st_ff.ph)
            S_IDLE:
            begin
                if (rx_i.valid && st_ff.ctrl[CTRL_ENABLE]) // [R12]
                begin
                    if (!st_ff.ctrl[CTRL_DECOUPLED] && !host_ready_i)
                    begin
                        // Coupled: port refuses whole frame
                        nxt_st.port_drop =
                            DROP_W'(st_ff.port_drop + 1'b1); // [R9]
                        nxt_st.ph = rx_i.last ? S_IDLE : S_SKIP;
                    end
                    else if (st_ff.ctrl[CTRL_DECOUPLED] && !stream_ready_i)
                    begin
                        // Decoupled: this stream alone drops the frame
                        nxt_st.stream_drop =
                            DROP_W'(st_ff.stream_drop + 1'b1); // [R8]
                        nxt_st.ph = rx_i.last ? S_IDLE : S_SKIP;
                    end
                    else
                    begin
                        nxt_st.hold = rx_i.data;
                        nxt_st.hold_vld = 1'b1;
                        nxt_st.taken = 14'h1;
                        nxt_st.wlen = 14'h1;
                        nxt_st.hidx = 5'h0;
                        nxt_st.ph = S_BODY;
                        if (rx_i.last)
                            nxt_st.ph = S_HDR;
                    end
                end
                else if (rx_i.valid && !rx_i.last)
                    nxt_st.ph = S_SKIP;
            end
            S_SKIP:
            begin
                if (rx_i.valid && rx_i.last)
                    nxt_st.ph = S_IDLE;
            end
            S_BODY:
            begin
                // Count whole frame for wire length; body bytes are not stored
                if (rx_i.valid)
                begin
                    nxt_st.wlen = st_ff.wlen + 14'h1;
                    if (rx_i.last)
                        nxt_st.ph = S_HDR;
                end
            end
            S_HDR:
            begin
                // Emit header bytes: wire length, stored length, then zero fields
                if (host_ready_i || st_ff.ctrl[CTRL_DECOUPLED])
                begin
                    pk_vld = 1'b1;
                    if (st_ff.hidx == 5'h0)
                        pk_byte = 8'((st_ff.wlen - fcs_cut) >> 8); // [R7]
                    else if (st_ff.hidx == 5'h1)
                        pk_byte = 8'(st_ff.wlen - fcs_cut); // [R7]
                    else if (st_ff.hidx == 5'h2)
                    begin
                        // Stored length: captured body only, cut to the body budget
                        if (st_ff.wlen - fcs_cut > snap_body)
                            pk_byte = 8'(snap_body); // [R3]
                        else
                            pk_byte = 8'(st_ff.wlen - fcs_cut); // [R3]
                    end
                    else
                        pk_byte = 8'h0;
                    nxt_st.hidx = st_ff.hidx + 5'h1;
                    if (st_ff.hidx == 5'(HDR_LEN - 14'h1)) // [R4]
                    begin
                        pk_last = 1'b1; // [R6]
                        nxt_st.ph = S_IDLE;
                    end
                end
            end
            default: nxt_st.ph = S_IDLE;
        endcase

        // Commands; clear wins over set by events
        if (reg_req_i.wr && reg_req_i.addr == REG_CMD)
        begin
            if (reg_req_i.wdata[CMD_START])
                nxt_st.stream_drop = '0; // [R11]
            if (reg_req_i.wdata[CMD_IMAGE_RESET])
            begin
                nxt_st.port_drop = '0; // [R10] [R18]
                nxt_st.ph = S_IDLE;
                nxt_st.hold_vld = 1'b0;
            end
            if (reg_req_i.wdata[CMD_DEFAULT])
            begin
                nxt_st.ctrl = CTRL_RESET; // [R19] [R12]
                nxt_st.snap = SNAP_RESET; // [R19] [R2]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            st_ff <= '0;
            st_ff.ctrl <= CTRL_RESET; // [R12]
            st_ff.snap <= SNAP_RESET; // [R2]
        end
        else
            st_ff <= nxt_st;
    end

    ////////////////////////////////////////////////////////////////////////
    // Record packer, pads to 64-bit words
    record_packer u_packer (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .byte_vld_i(pk_vld),
        .byte_i(pk_byte),
        .byte_last_i(pk_last),
        .word_o(rec_o)
    ); // [R6]

    ////////////////////////////////////////////////////////////////////////
    // Loopbacks and line controls
    always_comb
    begin
        line_tx_o = '0;
        host_lb_o = '0;
        if (st_ff.ctrl[CTRL_FAC_LB])
            line_tx_o = rx_i; // [R14]
        else if (!st_ff.ctrl[CTRL_EQUIP_LB])
            line_tx_o = host_tx_i;
        if (st_ff.ctrl[CTRL_EQUIP_LB])
            host_lb_o = host_tx_i; // [R13]
    end

    assign laser_on_o = st_ff.ctrl[CTRL_LASER]; // [R15]
    assign tx_clk_master_o = st_ff.ctrl[CTRL_CLK_MASTER]; // [R17]
    assign buf_overlap_o = st_ff.ctrl[CTRL_OVERLAP]; // [R22]
    // Coupled mode: line paced by slowest stream
    assign rx_ready_o = st_ff.ctrl[CTRL_DECOUPLED] ? 1'b1 : host_ready_i; // [R9]
    assign reg_rdata_o = st_ff.rdata;
endmodule

// ===== bench/capture_record_formatter_chk.sv
// Port assertions for the capture record formatter
`timescale 1ns/100ps
module capture_record_formatter_chk
    import capture_pkg::*;
#(
    parameter int DROP_W = 32
)
(
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire reg_req_t reg_req_i,
    input wire logic [31:0] reg_rdata_o,
    input wire rx_byte_t rx_i,
    input wire logic rx_lock_i,
    input wire logic host_ready_i,
    input wire rx_byte_t host_tx_i,
    input wire logic rx_ready_o,
    input wire rx_byte_t line_tx_o,
    input wire rx_byte_t host_lb_o,
    input wire logic laser_on_o,
    input wire logic tx_clk_master_o,
    input wire logic buf_overlap_o
);
logic [7:0] sh_ff, sh1_ff, sh2_ff;
logic calm;
////////////////////////////////////////////////////////////////////////////
// Shadow of the control bits; outputs are judged once it has settled
always_ff @(posedge ref_clk_i)
begin
    sh1_ff <= sys_rst_i ? CTRL_RESET : sh_ff;
    sh2_ff <= sys_rst_i ? CTRL_RESET : sh1_ff;
    if (sys_rst_i)
        sh_ff <= CTRL_RESET;
    else if (reg_req_i.wr && reg_req_i.addr == REG_CMD
        && reg_req_i.wdata[CMD_DEFAULT])
        sh_ff <= CTRL_RESET;
    else if (reg_req_i.wr && reg_req_i.addr == REG_CTRL)
        sh_ff <= reg_req_i.wdata[7:0];
end
assign calm = (sh_ff == sh1_ff) && (sh1_ff == sh2_ff);
////////////////////////////////////////////////////////////////////////////
default clocking cb @(posedge ref_clk_i); endclocking
default disable iff (sys_rst_i);
// Status read, answered in the next cycle
sequence status_read;
    reg_req_i.rd && reg_req_i.addr == REG_STATUS;
endsequence
chk_laser_bit: assert property (
    calm |-> laser_on_o == sh_ff[CTRL_LASER]) else $error("laser wrong");
chk_clock_source: assert property (
    calm |-> tx_clk_master_o == sh_ff[CTRL_CLK_MASTER])
    else $error("clock source wrong");
chk_overlap_bit: assert property (
    calm |-> buf_overlap_o == sh_ff[CTRL_OVERLAP]) else $error("overlap");
chk_coupled_pace: assert property (
    calm && !sh_ff[CTRL_DECOUPLED] |-> rx_ready_o == host_ready_i)
    else $error("coupled pacing wrong");
chk_decoupled_free: assert property (
    calm && sh_ff[CTRL_DECOUPLED] |-> rx_ready_o)
    else $error("decoupled stream throttled");
chk_equip_loop: assert property (
    calm && sh_ff[CTRL_EQUIP_LB] |-> host_lb_o == host_tx_i)
    else $error("equipment loop wrong");
chk_facility_loop: assert property (
    calm && sh_ff[CTRL_FAC_LB] && rx_i.valid |-> line_tx_o == rx_i)
    else $error("facility loop wrong");
chk_lock_read: assert property (
    status_read |=> reg_rdata_o[0] == $past(rx_lock_i))
    else $error("lock status wrong");
endmodule

bind capture_record_formatter capture_record_formatter_chk
    #(.DROP_W(DROP_W)) chk_inst (.ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i), .reg_req_i(reg_req_i), .rx_i(rx_i),
    .reg_rdata_o(reg_rdata_o), .rx_lock_i(rx_lock_i),
    .host_ready_i(host_ready_i), .host_tx_i(host_tx_i),
    .rx_ready_o(rx_ready_o), .line_tx_o(line_tx_o),
    .host_lb_o(host_lb_o), .laser_on_o(laser_on_o),
    .tx_clk_master_o(tx_clk_master_o), .buf_overlap_o(buf_overlap_o));

// ===== bench/host_memory_model.sv
// Host memory model: paces and tallies record words
`timescale 1ns/100ps
module host_memory_model
    import capture_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic stall_i,
    input wire logic slow_i,
    input wire rec_word_t rec_i,
    output logic host_ready_o,
    output logic stream_ready_o,
    output int words_o,
    output int recs_o,
    output logic [63:0] first_o
);
logic tick_ff;
logic start_ff;
// Buffer split stays fixed, so room hangs on the stall request only
assign stream_ready_o = !stall_i;
// A slow host is ready only every other cycle
assign host_ready_o = !stall_i && (!slow_i || tick_ff);
// Count words and records, keep the first word of each record
always_ff @(posedge ref_clk_i)
begin
    tick_ff <= !tick_ff && !sys_rst_i;
    if (sys_rst_i)
    begin
        start_ff <= 1'b1;
        words_o <= 0;
        recs_o <= 0;
    end
    else if (rec_i.valid)
    begin
        words_o <= words_o + 1;
        recs_o <= recs_o + int'(rec_i.last);
        start_ff <= rec_i.last;
        if (start_ff)
            first_o <= rec_i.data;
    end
end
endmodule

// ===== bench/test_capture_record_formatter.sv
// Self-checking bench for the capture record formatter
`timescale 1ns/100ps
module test_capture_record_formatter
    import capture_pkg::*;
;
logic ref_clk, sys_rst, lock, stall, slow, rx_ready;
logic laser, master, overlap, host_ready, stream_ready;
reg_req_t req;
rx_byte_t rx, host_tx, line_tx, host_lb;
rec_word_t rec;
logic [31:0] rdata;
logic [63:0] first;
int words, recs, failures, checks;
////////////////////////////////////////////////////////////////////////////
capture_record_formatter capture_record_formatter_inst (
    .ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .reg_req_i(req),
    .reg_rdata_o(rdata), .rx_i(rx), .rx_lock_i(lock),
    .host_ready_i(host_ready), .stream_ready_i(stream_ready),
    .rec_o(rec), .rx_ready_o(rx_ready), .host_tx_i(host_tx),
    .line_tx_o(line_tx), .host_lb_o(host_lb), .laser_on_o(laser),
    .tx_clk_master_o(master), .buf_overlap_o(overlap));
host_memory_model host_memory_model_inst (
    .ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .stall_i(stall),
    .slow_i(slow), .rec_i(rec), .host_ready_o(host_ready),
    .stream_ready_o(stream_ready), .words_o(words), .recs_o(recs),
    .first_o(first));
////////////////////////////////////////////////////////////////////////////
task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp)
    begin
        failures++;
        $display("BAD %0t got %h exp %h", $time, got, exp);
    end
endtask
task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    req <= '0;
endtask
task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge ref_clk);
    req <= '0;
    #1 check(64'(rdata), 64'(e));
endtask
// One received frame, byte value equal to the low byte of its index
task automatic frame(input int n);
    for (int i = 0; i < n; i++)
    begin
        @(posedge ref_clk);
        rx <= '{valid: 1'b1, data: i[7:0], last: i == n - 1};
    end
    @(posedge ref_clk);
    rx <= '0;
endtask
task automatic wait_rec(input int r0);
    for (int i = 0; i < 80 && recs == r0; i++)
        @(posedge ref_clk) #1;
    check(64'(recs - r0), 64'h1);
endtask
// Frame in, record out; header words and length fields judged
task automatic record(input int n, input logic [15:0] wl,
    input logic [7:0] st);
    int r0, w0;
    r0 = recs;
    w0 = words;
    frame(n);
    wait_rec(r0);
    check(64'(words - w0), 64'((HDR_LEN + 14'h7) / 14'h8));
    check(64'(first[23:16]), 64'(st));
    check(64'(first[15:0] == wl || first[15:0] == {wl[7:0], wl[15:8]}), 1);
endtask
task automatic print_verdict;
    $display("failures %0d checks %0d", failures, checks);
    if (failures == 0 && checks > 0)
        $display("verification passed");
    else
        $display("verification failed");
    $finish;
endtask
////////////////////////////////////////////////////////////////////////////
task automatic t_defaults;
    reg_rd(REG_CTRL, {24'h0, CTRL_RESET});
    reg_rd(REG_SNAP, {18'h0, SNAP_RESET});
    reg_rd(4'hf, 32'h0);
    lock <= 1'b1;
    reg_rd(REG_STATUS, 32'h1);
    lock <= 1'b0;
    reg_rd(REG_STATUS, 32'h0);
endtask
task automatic t_snap;
    logic [13:0] v [6] = '{14'h00c8, 14'h002f, 14'h0034, 14'h0028,
        14'h2588, 14'h2580};
    logic [13:0] e;
    e = SNAP_RESET;
    foreach (v[i])
    begin
        if (v[i][2:0] == 3'h0 && v[i] >= SNAP_MIN && v[i] <= SNAP_MAX)
            e = v[i];
        reg_wr(REG_SNAP, {18'h0, v[i]});
        reg_rd(REG_SNAP, {18'h0, e});
    end
endtask
task automatic t_records;
    reg_wr(REG_SNAP, 32'h30);
    record(100, 16'h0064, 8'h2e);
    reg_wr(REG_CTRL, 32'h3);
    record(30, 16'h001a, 8'h1a);
    reg_wr(REG_SNAP, 32'hc8);
    record(300, 16'h0128, 8'hc6);
endtask
task automatic t_drops;
    stall <= 1'b1;
    frame(20);
    reg_rd(REG_PORT_DROP, 32'h1);
    reg_wr(REG_CMD, 32'h1);
    reg_rd(REG_PORT_DROP, 32'h0);
    reg_rd(REG_CTRL, 32'h3);
    reg_wr(REG_CTRL, 32'h7);
    frame(20);
    reg_rd(REG_STREAM_DROP, 32'h1);
    reg_rd(REG_PORT_DROP, 32'h0);
    check(64'(rx_ready), 64'h1);
    stall <= 1'b0;
    slow <= 1'b1;
    record(40, 16'h0024, 8'h24);
    reg_wr(REG_CMD, 32'h4);
    reg_rd(REG_STREAM_DROP, 32'h0);
    slow <= 1'b0;
endtask
task automatic t_ctrl;
    int r0;
    r0 = recs;
    reg_wr(REG_CTRL, 32'h0);
    frame(20);
    repeat (40) @(posedge ref_clk);
    check(64'(recs - r0), 64'h0);
    reg_wr(REG_CTRL, 32'hf9);
    repeat (2) @(posedge ref_clk);
    rx <= '{valid: 1'b1, data: 8'h5a, last: 1'b1};
    host_tx <= '{valid: 1'b1, data: 8'ha5, last: 1'b0};
    #1 check(64'({laser, master, overlap}), 64'h7);
    check(64'(line_tx), 64'(rx));
    check(64'(host_lb), 64'(host_tx));
    @(posedge ref_clk);
    rx <= '0;
    host_tx <= '0;
    wait_rec(r0);
    reg_wr(REG_CMD, 32'h2);
    reg_rd(REG_CTRL, 32'h1);
    reg_rd(REG_SNAP, 32'h30);
    check(64'({laser, master, overlap}), 64'h0);
endtask
////////////////////////////////////////////////////////////////////////////
initial
begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
end
// Reset, initialise the card, then run the scenarios
initial
begin
    {sys_rst, lock, stall, slow} = 4'h8;
    {req, rx, host_tx} = '0;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    reg_wr(REG_CMD, 32'h2);
    t_defaults;
    t_snap;
    t_records;
    t_drops;
    t_ctrl;
    print_verdict;
end
// Watchdog against a hung handshake
initial
begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    print_verdict;
end
endmodule
